// File: pbm_pkg.sv
// Package of constants and types for the Port B / upper Port C alternate function mux
// Notes on behaviour
// - Pin B7 used as clock pin reads zero on direction, latch and input bits.
// - Pin B6 used as clock pin reads zero on direction, latch and input bits.
// - Async timer clock on detaches B7 from GPIO as oscillator amplifier output only while an external clock is selected.
// - Async timer clock on detaches B6 from GPIO as oscillator amplifier input.
// - B6 overrides enabled for internal RC or async timer; values are zero.
// - B7 overrides enabled for external clock and (internal RC or async timer).
// - SPI slave forces clock pin input; master uses direction bit and drives clock.
// - SPI master forces data-in pin input; slave uses direction bit, drives output.
// - SPI slave forces data-out pin input; master uses its direction bit.
// - SPI slave forces select pin input; SPI active only while it is low.
// - Forced SPI inputs keep pull-up from latch bit gated by global disable.
// - Master receive shares slave transmit pin; master transmit shares slave receive.
// - B3 value override from SPI master or timer2 compare; values combined.
// - B0 digital input feeds timer1 capture; no overrides active.
// - Reset disable fuse programmed makes C6 ordinary I/O, else reset input.
// - C6 used as reset reads zero on direction, latch and input bits.
// - Two-wire enable makes C5 open-drain clock line with 50 ns spike filter.
// - Without pull-up override, pull-up on when direction,latch,disable equal 010.
// - Driver enable follows direction override value when enabled, else direction bit.
// - Value override sets driven value; input enable override replaces sleep state.
package pbm_pkg;
    localparam int NPIN_B = 8;
    localparam int PIN_C5 = 5;
    localparam int PIN_C6 = 6;
    // Pull-up pattern {direction, latch, global disable}
    localparam logic [2:0] PULLUP_PATTERN = 3'h2;
    // Spike filter on the two-wire clock input
    localparam int CLK_MHZ = 50;
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYC_RAW = (SPIKE_NS * CLK_MHZ + 999) / 1000;
    localparam int SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
    localparam logic [3:0] SPIKE_CNT = 4'(SPIKE_CYC);

    // Override bundle for one pin
    typedef struct packed {
        logic pu_oe;
        logic pu_ov;
        logic dd_oe;
        logic dd_ov;
        logic pv_oe;
        logic pv_ov;
        logic die_oe;
        logic die_ov;
    } pbm_ovr_t;

    // Spike filter state
    typedef struct packed {
        logic [1:0] sync;
        logic [3:0] cnt;
        logic       level;
    } pbm_filt_t;
endpackage

// File: pbm_filt_if.sv
// Interface carrying the raw pin and its filtered level to the spike filter
interface pbm_filt_if;
    logic raw;
    logic level;
    modport owner (output raw, input level);
    modport filt  (input raw, output level);
endinterface

// File: pbm_spike_filter.sv
// Spike filter: synchronises a pin and passes only levels stable for the minimum time
module pbm_spike_filter (
    input  wire logic clk,
    input  wire logic rst_n,
    pbm_filt_if.filt  fi
);
    pbm_pkg::pbm_filt_t st_r;
    pbm_pkg::pbm_filt_t st_nxt;

    // Two-flop sync, then a level change must persist for the spike time
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync = {st_r.sync[0], fi.raw};
        if (st_r.sync[1] == st_r.level) begin
            st_nxt.cnt = 4'h0;
        end else if (st_r.cnt + 4'h1 >= pbm_pkg::SPIKE_CNT) begin
            st_nxt.level = st_r.sync[1];
            st_nxt.cnt   = 4'h0;
        end else begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end
    end

    // Idle line is high (open-drain with pull-up)
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '{sync: 2'h3, cnt: 4'h0, level: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fi.level = st_r.level;
endmodule

// File: pbm_port_mux.sv
// Port B and Port C6/C5 alternate function override mux with generic pin cells
module pbm_port_mux (
    input  wire logic       CORE_CLK,
    input  wire logic       RESETN,
    // GPIO register bits
    input  wire logic [7:0] PORTB_DIR,
    input  wire logic [7:0] PORTB_LATCH,
    input  wire logic       LATCH_BIT_B_DIRECTION_BIT,
    input  wire logic       LATCH_BIT_B,
    input  wire logic       PORTC5_DIR,
    input  wire logic       PORTC5_LATCH,
    input  wire logic       GLOBAL_PULLUP_DISABLE,
    input  wire logic       SLEEP_ACTIVE,
    // Clock and reset configuration
    input  wire logic       ASYNC_TIMER_CLOCK_BIT,
    input  wire logic       INTERNAL_RC_SELECTED,
    input  wire logic       EXTERNAL_CLOCK_SELECTED,
    input  wire logic       RESET_DISABLE_FUSE,
    // SPI
    input  wire logic       SPI_ENABLE_BIT,
    input  wire logic       SPI_MASTER_SELECT,
    input  wire logic       SPI_SCK_OUT,
    input  wire logic       SPI_MASTER_OUT,
    input  wire logic       SPI_SLAVE_OUT,
    output logic            SPI_SCK_IN,
    output logic            SPI_MASTER_IN,
    output logic            SPI_SLAVE_IN,
    output logic            SPI_SLAVE_SELECT_N,
    output logic            SPI_SLAVE_ACTIVE,
    // Timers
    input  wire logic       TIMER2_COMPARE_OUT,
    input  wire logic       TIMER2_COMPARE_EN,
    input  wire logic       TIMER1_COMPARE_A_OUT,
    input  wire logic       TIMER1_COMPARE_A_EN,
    input  wire logic       TIMER1_COMPARE_B_OUT,
    input  wire logic       TIMER1_COMPARE_B_EN,
    output logic            TIMER1_CAPTURE_IN,
    // Oscillator and reset taps (analog side)
    output logic            OSC_AMP_INPUT_SEL,
    output logic            OSC_AMP_OUTPUT_SEL,
    output logic            TIMER_OSC_INPUT_SEL,
    output logic            TIMER_OSC_OUTPUT_SEL,
    output logic            RESET_PIN_SEL,
    output logic            RESET_PIN_LEVEL_N,
    // Two-wire clock line
    input  wire logic       TWO_WIRE_ENABLE_BIT,
    input  wire logic       TWO_WIRE_CLK_OUT,
    output logic            TWO_WIRE_CLK_IN,
    // Readback of port bits
    output logic [7:0]      PORTB_DIR_RD,
    output logic [7:0]      PORTB_LATCH_RD,
    output logic [7:0]      PORTB_INPUT_RD,
    output logic            LATCH_BIT_B_DIR_RD,
    output logic            LATCH_BIT_B_LATCH_RD,
    output logic            LATCH_BIT_B_INPUT_RD,
    output logic            PORTC5_INPUT_RD,
    // Pads
    input  wire logic [7:0] PADB_IN,
    output logic [7:0]      PADB_OUT,
    output logic [7:0]      PADB_OE,
    output logic [7:0]      PADB_PULLUP,
    input  wire logic       PADC6_IN,
    output logic            PADC6_OUT,
    output logic            PADC6_OE,
    output logic            PADC6_PULLUP,
    input  wire logic       PADC5_IN,
    output logic            PADC5_OUT,
    output logic            PADC5_OE,
    output logic            PADC5_PULLUP
);
    localparam int NB = pbm_pkg::NPIN_B;

    // Pin cell: pull-up, driver enable and value from overrides
    function automatic logic [2:0] pin_cell(input pbm_pkg::pbm_ovr_t o, input logic dir,
                                            input logic latch, input logic global_pullup_disable);
        logic pu;
        logic oe;
        logic val;
        pu  = o.pu_oe ? o.pu_ov : ({dir, latch, global_pullup_disable} == pbm_pkg::PULLUP_PATTERN);
        oe  = o.dd_oe ? o.dd_ov : dir;
        val = (o.pv_oe ? o.pv_ov : latch) & oe;
        return {pu & ~oe, oe, val};
    endfunction

    // Input enable: override value or awake state
    function automatic logic in_en(input pbm_pkg::pbm_ovr_t o, input logic sleep);
        return o.die_oe ? o.die_ov : ~sleep;
    endfunction

    // Registered state: two-flop synchronisers and the synced pin values
    typedef struct packed {
        logic [7:0] b_s1;
        logic [7:0] b_s2;
        logic       c6_s1;
        logic       c6_s2;
    } pbm_state_t;

    pbm_state_t st_r;
    pbm_state_t st_nxt;

    pbm_pkg::pbm_ovr_t ob [NB];
    pbm_pkg::pbm_ovr_t oc6;
    pbm_pkg::pbm_ovr_t oc5;
    logic              spi_m;
    logic              spi_s;
    logic              osc_b6;
    logic              osc_b7;
    logic              rst_pin;
    logic [7:0]        b_ien;
    logic [7:0]        b_din;

    pbm_filt_if fif ();

    // Spike filter only looks at the two-wire clock pad
    pbm_spike_filter u_filt (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .fi    (fif)
    );
    assign fif.raw = PADC5_IN;

    // Synchronise pad levels before any logic sees them
    always_comb begin
        st_nxt = st_r;
        st_nxt.b_s1  = PADB_IN;
        st_nxt.b_s2  = st_r.b_s1;
        st_nxt.c6_s1 = PADC6_IN;
        st_nxt.c6_s2 = st_r.c6_s1;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Takeover conditions
    assign spi_m   = SPI_ENABLE_BIT & SPI_MASTER_SELECT;
    assign spi_s   = SPI_ENABLE_BIT & ~SPI_MASTER_SELECT;
    assign osc_b6  = INTERNAL_RC_SELECTED | ASYNC_TIMER_CLOCK_BIT;
    assign osc_b7  = EXTERNAL_CLOCK_SELECTED & osc_b6;
    assign rst_pin = ~RESET_DISABLE_FUSE;

    // Override tables, all combinational so takeover is same-cycle
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            ob[i] = '0;
        end
        // B7/B6 oscillator pins: everything off, values zero
        ob[7] = '{pu_oe: osc_b7, pu_ov: 1'b0, dd_oe: osc_b7, dd_ov: 1'b0, pv_oe: 1'b0,
                  pv_ov: 1'b0, die_oe: osc_b7, die_ov: 1'b0};
        ob[6] = '{pu_oe: osc_b6, pu_ov: 1'b0, dd_oe: osc_b6, dd_ov: 1'b0, pv_oe: 1'b0,
                  pv_ov: 1'b0, die_oe: osc_b6, die_ov: 1'b0};
        // SPI forced inputs keep latch-driven pull-up
        for (int i = 2; i <= 5; i++) begin
            ob[i].pu_ov = PORTB_LATCH[i] & ~GLOBAL_PULLUP_DISABLE;
        end
        // SCK: forced input in slave, clock out in master
        ob[5].pu_oe = spi_s;
        ob[5].dd_oe = spi_s;
        ob[5].pv_oe = spi_m;
        ob[5].pv_ov = SPI_SCK_OUT;
        // Data-in pin: forced input in master, slave output drives it
        ob[4].pu_oe = spi_m;
        ob[4].dd_oe = spi_m;
        ob[4].pv_oe = spi_s;
        ob[4].pv_ov = SPI_SLAVE_OUT;
        // Data-out pin: forced input in slave; master or timer2 drives it
        ob[3].pu_oe = spi_s;
        ob[3].dd_oe = spi_s;
        ob[3].pv_oe = spi_m | TIMER2_COMPARE_EN;
        ob[3].pv_ov = (spi_m & SPI_MASTER_OUT) | TIMER2_COMPARE_OUT;
        // Select pin: forced input in slave; timer1 B drives it when enabled
        ob[2].pu_oe = spi_s;
        ob[2].dd_oe = spi_s;
        ob[2].pv_oe = TIMER1_COMPARE_B_EN;
        ob[2].pv_ov = TIMER1_COMPARE_B_OUT;
        // Timer1 A; direction stays with software
        ob[1].pv_oe = TIMER1_COMPARE_A_EN;
        ob[1].pv_ov = TIMER1_COMPARE_A_OUT;
        // C6 reset pin: pull-up forced on, driver and input off
        oc6 = '{pu_oe: rst_pin, pu_ov: 1'b1, dd_oe: rst_pin, dd_ov: 1'b0, pv_oe: 1'b0,
                pv_ov: 1'b0, die_oe: rst_pin, die_ov: 1'b0};
        // C5 two-wire clock: open drain, driver on only to pull low
        oc5 = '{pu_oe: TWO_WIRE_ENABLE_BIT,
                pu_ov: PORTC5_LATCH & ~GLOBAL_PULLUP_DISABLE,
                dd_oe: TWO_WIRE_ENABLE_BIT, dd_ov: ~TWO_WIRE_CLK_OUT,
                pv_oe: TWO_WIRE_ENABLE_BIT, pv_ov: 1'b0,
                die_oe: 1'b0, die_ov: 1'b0};
    end

    // Port B pads and digital inputs
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            logic [2:0] c;
            c = pin_cell(ob[i], PORTB_DIR[i], PORTB_LATCH[i], GLOBAL_PULLUP_DISABLE);
            PADB_PULLUP[i] = c[2];
            PADB_OE[i]     = c[1];
            PADB_OUT[i]    = c[0];
            b_ien[i]       = in_en(ob[i], SLEEP_ACTIVE);
            b_din[i]       = st_r.b_s2[i] & b_ien[i];
        end
    end

    // Readback: clock pins report zero on all three bits
    always_comb begin
        PORTB_DIR_RD   = PORTB_DIR;
        PORTB_LATCH_RD = PORTB_LATCH;
        PORTB_INPUT_RD = b_din;
        if (osc_b7) begin
            PORTB_DIR_RD[7]   = 1'b0;
            PORTB_LATCH_RD[7] = 1'b0;
            PORTB_INPUT_RD[7] = 1'b0;
        end
        if (osc_b6) begin
            PORTB_DIR_RD[6]   = 1'b0;
            PORTB_LATCH_RD[6] = 1'b0;
            PORTB_INPUT_RD[6] = 1'b0;
        end
    end

    // Peripheral inputs; shared pins serve both SPI directions
    assign SPI_SCK_IN         = b_din[5];
    assign SPI_MASTER_IN      = b_din[4];
    assign SPI_SLAVE_IN       = b_din[3];
    assign SPI_SLAVE_SELECT_N = b_din[2];
    assign SPI_SLAVE_ACTIVE   = spi_s & ~b_din[2];
    assign TIMER1_CAPTURE_IN  = b_din[0];

    // Oscillator taps route the pads to the analog amplifier
    assign OSC_AMP_INPUT_SEL    = osc_b6 ? 1'b0 : 1'b1;
    assign OSC_AMP_OUTPUT_SEL   = ~osc_b6;
    assign TIMER_OSC_INPUT_SEL  = ASYNC_TIMER_CLOCK_BIT;
    assign TIMER_OSC_OUTPUT_SEL = ASYNC_TIMER_CLOCK_BIT;

    // C6 pin cell and reset tap
    always_comb begin
        logic [2:0] c;
        c = pin_cell(oc6, LATCH_BIT_B_DIRECTION_BIT, LATCH_BIT_B, GLOBAL_PULLUP_DISABLE);
        PADC6_PULLUP      = c[2];
        PADC6_OE          = c[1];
        PADC6_OUT         = c[0];
        RESET_PIN_SEL     = rst_pin;
        RESET_PIN_LEVEL_N = rst_pin ? st_r.c6_s2 : 1'b1;
        LATCH_BIT_B_DIR_RD     = rst_pin ? 1'b0 : LATCH_BIT_B_DIRECTION_BIT;
        LATCH_BIT_B_LATCH_RD   = rst_pin ? 1'b0 : LATCH_BIT_B;
        LATCH_BIT_B_INPUT_RD   = rst_pin ? 1'b0 : (st_r.c6_s2 & in_en(oc6, SLEEP_ACTIVE));
    end

    // C5 pin cell; filtered level feeds both port and two-wire clock
    always_comb begin
        logic [2:0] c;
        c = pin_cell(oc5, PORTC5_DIR, PORTC5_LATCH, GLOBAL_PULLUP_DISABLE);
        PADC5_PULLUP    = c[2];
        PADC5_OE        = c[1];
        PADC5_OUT       = c[0];
        TWO_WIRE_CLK_IN = TWO_WIRE_ENABLE_BIT ? fif.level : 1'b1;
        PORTC5_INPUT_RD = fif.level & in_en(oc5, SLEEP_ACTIVE);
    end
endmodule

// File: pbm_pad_model.sv
// Behavioural pad ring model: resolves each pad from driver, outside drive and pull-up
module pbm_pad_model #(
    parameter int W = 10
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] pull,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output logic      [W-1:0] pad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] last_r;

    // Our driver wins; a floating pad flips so a stale level never reads as valid
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe[i]) begin
                pad[i] = out[i];
            end else if (ext_en[i]) begin
                pad[i] = ext_val[i];
            end else begin
                pad[i] = pull[i] ? 1'b1 : ~last_r[i];
            end
        end
    end

    // Remember the last level for the floating case
    always_ff @(posedge clk) begin
        last_r <= pad;
    end
endmodule

// File: pbm_port_mux_asserts.sv
// Concurrent checks on the pin override mux ports
module pbm_port_mux_asserts (
    input wire logic       CORE_CLK,
    input wire logic       RESETN,
    input wire logic [7:0] PORTB_DIR,
    input wire logic [7:0] PORTB_LATCH,
    input wire logic       GLOBAL_PULLUP_DISABLE,
    input wire logic       SLEEP_ACTIVE,
    input wire logic       ASYNC_TIMER_CLOCK_BIT,
    input wire logic       INTERNAL_RC_SELECTED,
    input wire logic       EXTERNAL_CLOCK_SELECTED,
    input wire logic       RESET_DISABLE_FUSE,
    input wire logic       SPI_ENABLE_BIT,
    input wire logic       SPI_MASTER_SELECT,
    input wire logic       SPI_SCK_OUT,
    input wire logic       TIMER1_COMPARE_A_OUT,
    input wire logic       TIMER1_COMPARE_A_EN,
    input wire logic       TIMER1_CAPTURE_IN,
    input wire logic       RESET_PIN_SEL,
    input wire logic       TWO_WIRE_ENABLE_BIT,
    input wire logic       TWO_WIRE_CLK_OUT,
    input wire logic [7:0] PORTB_DIR_RD,
    input wire logic       LATCH_BIT_B_DIR_RD,
    input wire logic       LATCH_BIT_B_LATCH_RD,
    input wire logic [7:0] PADB_IN,
    input wire logic [7:0] PADB_OUT,
    input wire logic [7:0] PADB_OE,
    input wire logic [7:0] PADB_PULLUP,
    input wire logic       PADC6_OE,
    input wire logic       PADC5_OE,
    input wire logic       PADC5_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    logic spi_m;
    logic spi_s;
    logic b0_in;
    // Mode decodes shared by several checks
    assign spi_m = SPI_ENABLE_BIT & SPI_MASTER_SELECT;
    assign spi_s = SPI_ENABLE_BIT & ~SPI_MASTER_SELECT;
    assign b0_in = PADB_IN[0];

    b0_pullup_a: assert property (PADB_PULLUP[0] == ({PORTB_DIR[0], PORTB_LATCH[0],
        GLOBAL_PULLUP_DISABLE} == 3'h2)) else $error("B0 pull-up wrong");
    b0_driver_a: assert property (PADB_OE[0] == PORTB_DIR[0] &&
        (!PORTB_DIR[0] || PADB_OUT[0] == PORTB_LATCH[0])) else $error("B0 driver wrong");
    timer1_compare_a_out_value_a: assert property (PORTB_DIR[1] && TIMER1_COMPARE_A_EN |->
        PADB_OUT[1] == TIMER1_COMPARE_A_OUT) else $error("B1 compare value wrong");
    // Input clamp acts on the present sleep state, the pad level is two edges old
    capture_sync_a: assert property ($past(RESETN) && $past(RESETN, 2) &&
        !SLEEP_ACTIVE |->
        TIMER1_CAPTURE_IN == $past(b0_in, 2)) else $error("capture input not two edges late");
    spi_slave_in_a: assert property (spi_s |->
        PADB_OE[5] == 1'b0 && PADB_OE[3] == 1'b0 && PADB_OE[2] == 1'b0)
        else $error("slave pins not forced to input");
    spi_slave_pull_a: assert property (spi_s |-> PADB_PULLUP[5] ==
        (PORTB_LATCH[5] && !GLOBAL_PULLUP_DISABLE)) else $error("slave clock pull-up wrong");
    spi_master_a: assert property (spi_m |-> !PADB_OE[4] && PADB_OE[5] == PORTB_DIR[5] &&
        (!PORTB_DIR[5] || PADB_OUT[5] == SPI_SCK_OUT)) else $error("master pins wrong");
    osc_b6_a: assert property (INTERNAL_RC_SELECTED || ASYNC_TIMER_CLOCK_BIT |->
        !PADB_OE[6] && !PADB_PULLUP[6]) else $error("B6 not taken by oscillator");
    osc_b7_a: assert property (EXTERNAL_CLOCK_SELECTED &&
        (INTERNAL_RC_SELECTED || ASYNC_TIMER_CLOCK_BIT) |-> !PADB_OE[7] && !PADB_PULLUP[7] &&
        !PORTB_DIR_RD[7]) else $error("B7 not taken by oscillator");
    reset_pin_a: assert property (!RESET_DISABLE_FUSE |-> RESET_PIN_SEL && !PADC6_OE &&
        !LATCH_BIT_B_DIR_RD && !LATCH_BIT_B_LATCH_RD) else $error("C6 not held as reset pin");
    twi_drive_a: assert property (TWO_WIRE_ENABLE_BIT |-> PADC5_OE == !TWO_WIRE_CLK_OUT &&
        (!PADC5_OE || !PADC5_OUT)) else $error("C5 not open drain");
endmodule

bind pbm_port_mux pbm_port_mux_asserts i_chk (.*);

// File: testbench.sv
// Self-checking bench for the pin override mux with a pad model on the far side
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CORE_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [7:0] PORTB_DIR, PORTB_LATCH, PADB_OUT, PADB_OE, PADB_PULLUP;
    logic [7:0] PORTB_DIR_RD, PORTB_LATCH_RD, PORTB_INPUT_RD;
    logic LATCH_BIT_B_DIRECTION_BIT, LATCH_BIT_B, PORTC5_DIR, PORTC5_LATCH, GLOBAL_PULLUP_DISABLE;
    logic SLEEP_ACTIVE, ASYNC_TIMER_CLOCK_BIT, INTERNAL_RC_SELECTED, EXTERNAL_CLOCK_SELECTED;
    logic RESET_DISABLE_FUSE, SPI_ENABLE_BIT, SPI_MASTER_SELECT, SPI_SCK_OUT, SPI_MASTER_OUT;
    logic SPI_SLAVE_OUT, TIMER2_COMPARE_OUT, TIMER2_COMPARE_EN, TIMER1_COMPARE_A_OUT;
    logic TIMER1_COMPARE_A_EN, TIMER1_COMPARE_B_OUT, TIMER1_COMPARE_B_EN;
    logic TWO_WIRE_ENABLE_BIT, TWO_WIRE_CLK_OUT, TWO_WIRE_CLK_IN;
    logic SPI_SCK_IN, SPI_MASTER_IN, SPI_SLAVE_IN, SPI_SLAVE_SELECT_N, SPI_SLAVE_ACTIVE;
    logic TIMER1_CAPTURE_IN, OSC_AMP_INPUT_SEL, OSC_AMP_OUTPUT_SEL, TIMER_OSC_INPUT_SEL;
    logic TIMER_OSC_OUTPUT_SEL, RESET_PIN_SEL, RESET_PIN_LEVEL_N;
    logic LATCH_BIT_B_DIR_RD, LATCH_BIT_B_LATCH_RD, LATCH_BIT_B_INPUT_RD, PORTC5_INPUT_RD;
    logic PADC6_OUT, PADC6_OE, PADC6_PULLUP, PADC5_OUT, PADC5_OE, PADC5_PULLUP;
    wire logic [7:0] PADB_IN;
    wire logic PADC6_IN, PADC5_IN;
    logic [9:0] ext_en = 10'h3ff;
    logic [9:0] ext_val = 10'h000;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    pbm_port_mux i_dut (.*);
    pbm_pad_model #(.W(10)) i_pad (.clk(CORE_CLK), .oe({PADC5_OE, PADC6_OE, PADB_OE}),
        .out({PADC5_OUT, PADC6_OUT, PADB_OUT}), .pull({PADC5_PULLUP, PADC6_PULLUP, PADB_PULLUP}),
        .ext_en(ext_en), .ext_val(ext_val), .pad({PADC5_IN, PADC6_IN, PADB_IN}));

    // Clock at 50 MHz, and a ceiling far above the expected run length
    always #10 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask
    // Outside drive on one pad: index 8 is C6, 9 is C5
    task automatic pad(input int i, input logic v);
        ext_en[i] = 1'b1;
        ext_val[i] = v;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, err_total);
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence: inputs settle at time zero, reset for five cycles
    initial begin
        {PORTB_DIR, PORTB_LATCH, LATCH_BIT_B_DIRECTION_BIT, LATCH_BIT_B, PORTC5_DIR, PORTC5_LATCH,
         GLOBAL_PULLUP_DISABLE, SLEEP_ACTIVE, ASYNC_TIMER_CLOCK_BIT, INTERNAL_RC_SELECTED,
         EXTERNAL_CLOCK_SELECTED, RESET_DISABLE_FUSE, SPI_ENABLE_BIT, SPI_MASTER_SELECT,
         SPI_SCK_OUT, SPI_MASTER_OUT, SPI_SLAVE_OUT, TIMER2_COMPARE_OUT, TIMER2_COMPARE_EN,
         TIMER1_COMPARE_A_OUT, TIMER1_COMPARE_A_EN, TIMER1_COMPARE_B_OUT, TIMER1_COMPARE_B_EN,
         TWO_WIRE_ENABLE_BIT, TWO_WIRE_CLK_OUT} = '0;
        tick(5);
        RESETN = 1'b1;
        tick(3);
        // Plain pin cell, pull-up pattern, capture path and sleep clamp
        PORTB_LATCH = 8'h01;
        ext_en[0] = 1'b0;
        tick(3);
        chk(PADB_PULLUP[0], 1'b1, "B0 pull-up");
        chk(TIMER1_CAPTURE_IN, 1'b1, "capture input");
        GLOBAL_PULLUP_DISABLE = 1'b1;
        tick(1);
        chk(PADB_PULLUP[0], 1'b0, "B0 pull-up disabled");
        PORTB_DIR = 8'h01;
        tick(1);
        chk({PADB_OE[0], PADB_OUT[0]}, 2'h3, "B0 driver");
        PORTB_DIR = 8'h00;
        SLEEP_ACTIVE = 1'b1;
        pad(0, 1'b1);
        tick(3);
        chk(PORTB_INPUT_RD[0], 1'b0, "B0 input clamped in sleep");
        SLEEP_ACTIVE = 1'b0;
        done("gpio");
        // Timer compare outputs, direction set first by software
        PORTB_DIR = 8'h0e;
        {TIMER2_COMPARE_EN, TIMER1_COMPARE_A_EN, TIMER1_COMPARE_B_EN} = 3'h7;
        for (int v = 0; v < 2; v++) begin
            {TIMER2_COMPARE_OUT, TIMER1_COMPARE_A_OUT, TIMER1_COMPARE_B_OUT} = {3{v[0]}};
            tick(1);
            chk(PADB_OUT[3:1], {3{v[0]}}, "compare outputs");
        end
        done("timers");
        // SPI master: clock out, data-in forced input, shared data-out pin
        {TIMER1_COMPARE_A_EN, TIMER1_COMPARE_B_EN} = 2'h0;
        {SPI_ENABLE_BIT, SPI_MASTER_SELECT} = 2'h3;
        PORTB_DIR = 8'h38;
        for (int i = 0; i < 4; i++) begin
            {SPI_MASTER_OUT, TIMER2_COMPARE_OUT} = i[1:0];
            SPI_SCK_OUT = i[0];
            tick(1);
            chk(PADB_OUT[3], |i[1:0], "B3 combined value");
            chk({PADB_OE[5], PADB_OUT[5]}, {1'b1, i[0]}, "master clock");
            chk(PADB_OE[4], 1'b0, "master data-in forced");
        end
        pad(4, 1'b1);
        tick(3);
        chk(SPI_MASTER_IN, 1'b1, "master receive");
        done("spi master");
        // SPI slave: pins forced input, pull-up kept, select gates activity
        {SPI_MASTER_SELECT, TIMER2_COMPARE_EN, GLOBAL_PULLUP_DISABLE} = 3'h0;
        PORTB_DIR = 8'h3c;
        PORTB_LATCH = 8'h20;
        SPI_SLAVE_OUT = 1'b1;
        pad(2, 1'b0);
        pad(3, 1'b1);
        pad(5, 1'b1);
        tick(3);
        chk({PADB_OE[5], PADB_OE[3:2]}, 3'h0, "slave inputs forced");
        chk(PADB_PULLUP[5], 1'b1, "slave clock pull-up");
        chk({PADB_OE[4], PADB_OUT[4]}, 2'h3, "slave output");
        chk({SPI_SLAVE_ACTIVE, SPI_SLAVE_IN, SPI_SCK_IN}, 3'h7, "slave selected");
        pad(2, 1'b1);
        tick(3);
        chk(SPI_SLAVE_ACTIVE, 1'b0, "slave deselected");
        chk(SPI_SLAVE_SELECT_N, 1'b1, "select input high");
        SPI_ENABLE_BIT = 1'b0;
        done("spi slave");
        // Timer oscillator takes B6, then B7 once an external clock is chosen
        PORTB_DIR = 8'hc0;
        PORTB_LATCH = 8'hc0;
        pad(6, 1'b1);
        pad(7, 1'b1);
        ASYNC_TIMER_CLOCK_BIT = 1'b1;
        tick(3);
        chk({TIMER_OSC_INPUT_SEL, PADB_OE[6], PADB_PULLUP[6]}, 3'h4, "B6 oscillator");
        chk({PORTB_DIR_RD[6], PORTB_LATCH_RD[6], PORTB_INPUT_RD[6]}, 3'h0, "B6 reads");
        chk(PADB_OE[7], 1'b1, "B7 kept without external clock");
        chk(TIMER_OSC_OUTPUT_SEL, 1'b1, "timer oscillator output");
        chk({OSC_AMP_INPUT_SEL, OSC_AMP_OUTPUT_SEL}, 2'h0, "amplifier taps");
        EXTERNAL_CLOCK_SELECTED = 1'b1;
        tick(3);
        chk({PADB_OE[7], PORTB_DIR_RD[7], PORTB_LATCH_RD[7]}, 3'h0, "B7 oscillator");
        chk(PORTB_INPUT_RD[7], 1'b0, "B7 input read");
        // Internal RC with an external clock takes both pins without the timer oscillator
        {ASYNC_TIMER_CLOCK_BIT, INTERNAL_RC_SELECTED} = 2'h1;
        tick(1);
        chk({PADB_OE[7:6], OSC_AMP_OUTPUT_SEL}, 3'h0, "RC clock pins");
        {INTERNAL_RC_SELECTED, EXTERNAL_CLOCK_SELECTED} = 2'h0;
        tick(1);
        chk({PADB_OE[7:6], OSC_AMP_INPUT_SEL}, 3'h7, "clock pins freed");
        done("oscillator");
        // C6 as reset pin, then as plain I/O once the fuse is programmed
        {LATCH_BIT_B_DIRECTION_BIT, LATCH_BIT_B} = 2'h3;
        pad(8, 1'b1);
        tick(3);
        chk({RESET_PIN_SEL, PADC6_OE, LATCH_BIT_B_DIR_RD, LATCH_BIT_B_LATCH_RD}, 4'h8, "reset pin");
        chk(LATCH_BIT_B_INPUT_RD, 1'b0, "C6 input read");
        chk(PADC6_PULLUP, 1'b1, "reset pin pull-up");
        pad(8, 1'b0);
        tick(3);
        chk(RESET_PIN_LEVEL_N, 1'b0, "reset level");
        RESET_DISABLE_FUSE = 1'b1;
        tick(1);
        chk({RESET_PIN_SEL, PADC6_OE, PADC6_OUT}, 3'h3, "C6 as I/O");
        done("reset pin");
        // Two-wire clock: open drain, short low spike dropped, long low passed
        {TWO_WIRE_ENABLE_BIT, TWO_WIRE_CLK_OUT} = 2'h2;
        tick(1);
        chk({PADC5_OE, PADC5_OUT}, 2'h2, "C5 pulls low");
        TWO_WIRE_CLK_OUT = 1'b1;
        pad(9, 1'b1);
        tick(8);
        chk({PADC5_OE, TWO_WIRE_CLK_IN, PADC5_PULLUP}, 3'h2, "C5 released");
        pad(9, 1'b0);
        tick(2);
        pad(9, 1'b1);
        tick(8);
        chk({TWO_WIRE_CLK_IN, PORTC5_INPUT_RD}, 2'h3, "spike dropped");
        pad(9, 1'b0);
        tick(8);
        chk(TWO_WIRE_CLK_IN, 1'b0, "long low passed");
        done("two-wire");
        finish_test();
    end
endmodule
